// file: src/adc_input_select_and_results.sv
// Purpose: Register front end for converter input routing and results
// Assumes: AXI4-Lite slave, converter core delivers raw results with index
// Notes: Route codes leave as decoded one-hot style selects for the muxes
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module adc_input_select_and_results (
  input wire CLOCK,
  input wire RST_N,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire INPUT_ROUTE_CODE_DONE,
  input wire [2:0] INPUT_ROUTE_CODE_SLOT,
  input wire INPUT_ROUTE_CODE_SEQ,
  input wire [adc_sel_pkg::RAW_W-1:0] INPUT_ROUTE_CODE_RAW,
  output logic [15:0] POS_PIN_SEL0,
  output logic POS_DAC_SEL0,
  output logic POS_GND_SEL0,
  output logic [15:0] NEG_PIN_SEL0,
  output logic NEG_DAC_SEL0,
  output logic NEG_GND_SEL0,
  output logic [15:0] POS_PIN_SEL1,
  output logic POS_DAC_SEL1,
  output logic POS_GND_SEL1,
  output logic [15:0] NEG_PIN_SEL1,
  output logic NEG_DAC_SEL1,
  output logic NEG_GND_SEL1,
  output logic [3:0] REF_SEL_ONEHOT
);
  import adc_sel_pkg::*;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_RESP = 3'b100
  } rd_state_t;

  // Selector and control registers
  logic [ROUTE_W-1:0] sel_reg [8];
  logic [REF_W-1:0] ref_reg;
  logic [PREC_W-1:0] prec_reg;
  logic [31:0] last_value_reg [2];
  logic [31:0] params_reg;
  rd_state_t rd_state_reg;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic rd_from_store_reg;
  logic [31:0] rd_word_reg;
  logic rd_err_reg;
  logic [15:0] pos_pin_reg [2];
  logic [15:0] neg_pin_reg [2];
  logic [1:0] pos_dac_reg;
  logic [1:0] pos_gnd_reg;
  logic [1:0] neg_dac_reg;
  logic [1:0] neg_gnd_reg;
  logic [3:0] ref_onehot_reg;

  result_bus_if rbus ();

  result_store u_store (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .bus(rbus)
  );

  // Sign extension of a raw result to the selected precision
  function automatic logic [31:0] sign_extend(input logic [RAW_W-1:0] raw,
                                              input logic [PREC_W-1:0] prec);
    logic [31:0] v;
    v = 32'h00000000;
    case (prec)
      PREC_10: v = {{22{raw[9]}}, raw[9:0]};
      PREC_8: v = {{24{raw[7]}}, raw[7:0]};
      default: v = {{20{raw[RAW_W-1]}}, raw};
    endcase
    return v;
  endfunction : sign_extend

  // Selector address decode: offsets 0x00..0x1C map to index 0..7
  function automatic logic is_sel_addr(input logic [7:0] a);
    return (a[7:5] == 3'b000) && (a[1:0] == 2'b00);
  endfunction : is_sel_addr

  // Write channel decode
  wire wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  wire wr_sel_hit = is_sel_addr(aw_addr_reg);
  wire wr_ref_hit = aw_addr_reg == OFF_REF_SEL;
  wire wr_prec_hit = aw_addr_reg == OFF_PRECISION;
  wire wr_ok = wr_sel_hit || wr_ref_hit || wr_prec_hit;
  wire [2:0] wr_sel_idx = aw_addr_reg[4:2];

  // Read channel decode
  wire rd_take = S_AXI_ARVALID && (rd_state_reg == RD_IDLE);
  wire [7:0] rd_off = S_AXI_ARADDR - OFF_RESULT_BASE;
  wire rd_res_hit = (S_AXI_ARADDR >= OFF_RESULT_BASE) && (rd_off[7:2] < 6'(NUM_RESULTS))
    && (S_AXI_ARADDR[1:0] == 2'b00);
  wire rd_sel_hit = is_sel_addr(S_AXI_ARADDR);

  // Results slot write from the converter core
  assign rbus.wr_en = INPUT_ROUTE_CODE_DONE;
  assign rbus.wr_idx = INPUT_ROUTE_CODE_SLOT;
  assign rbus.wr_data = sign_extend(INPUT_ROUTE_CODE_RAW, prec_reg);
  assign rbus.rd_idx = rd_off[4:2];

  // Write address and data are caught in either order
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? AXI_OKAY : AXI_SLVERR; // Read-only words refuse writes
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Ready only while the slot is empty; registered so outputs come from flops
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_have_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
    end
  end

  // Selector, reference and precision stores; byte lane 0 carries all fields
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        sel_reg[i] <= 4'h0;
      end
      ref_reg <= REF_INT_1V;
      prec_reg <= PREC_12;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (wr_sel_hit) begin
        sel_reg[wr_sel_idx] <= w_data_reg[ROUTE_W-1:0];
      end
      if (wr_ref_hit) begin
        ref_reg <= w_data_reg[REF_W-1:0];
      end
      if (wr_prec_hit) begin
        prec_reg <= w_data_reg[PREC_W-1:0];
      end
    end
  end

  // Last value per sequencer, padded with the sign bit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      last_value_reg[0] <= 32'h00000000;
      last_value_reg[1] <= 32'h00000000;
    end else if (INPUT_ROUTE_CODE_DONE) begin
      last_value_reg[INPUT_ROUTE_CODE_SEQ] <= sign_extend(INPUT_ROUTE_CODE_RAW, prec_reg);
    end
  end

  // Fixed instance word; held in a flop so it is visible from reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      params_reg <= PARAMETERS_RESET;
    end else begin
      params_reg <= PARAMETERS_RESET;
    end
  end

  // Read word select for everything outside the result store
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (rd_sel_hit) begin
      rd_mux = {28'h0000000, sel_reg[S_AXI_ARADDR[4:2]]};
    end else if (S_AXI_ARADDR == OFF_REF_SEL) begin
      rd_mux = {30'h00000000, ref_reg};
    end else if (S_AXI_ARADDR == OFF_PRECISION) begin
      rd_mux = {30'h00000000, prec_reg};
    end else if (S_AXI_ARADDR == OFF_LAST_VALUE0) begin
      rd_mux = last_value_reg[0];
    end else if (S_AXI_ARADDR == OFF_LAST_VALUE1) begin
      rd_mux = last_value_reg[1];
    end else if (S_AXI_ARADDR == OFF_PARAMETERS) begin
      rd_mux = params_reg;
    end
  end
  wire rd_known = rd_sel_hit || rd_res_hit || (S_AXI_ARADDR == OFF_REF_SEL)
    || (S_AXI_ARADDR == OFF_PRECISION) || (S_AXI_ARADDR == OFF_LAST_VALUE0)
    || (S_AXI_ARADDR == OFF_LAST_VALUE1) || (S_AXI_ARADDR == OFF_PARAMETERS);

  // Read engine: result reads wait one cycle for the store's registered data
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_state_reg <= RD_IDLE;
      rd_from_store_reg <= 1'b0;
      rd_word_reg <= 32'h00000000;
      rd_err_reg <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= AXI_OKAY;
    end else begin
      S_AXI_ARREADY <= 1'b0;
      case (rd_state_reg)
        RD_IDLE: begin
          if (rd_take) begin
            S_AXI_ARREADY <= 1'b1;
            rd_from_store_reg <= rd_res_hit;
            rd_word_reg <= rd_mux;
            rd_err_reg <= !rd_known;
            rd_state_reg <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          S_AXI_RVALID <= 1'b1;
          S_AXI_RDATA <= rd_from_store_reg ? rbus.rd_data : rd_word_reg;
          S_AXI_RRESP <= rd_err_reg ? AXI_SLVERR : AXI_OKAY;
          rd_state_reg <= RD_RESP;
        end
        RD_RESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  // Route decode; unlisted codes select nothing at all
  function automatic logic [15:0] pin_onehot(input logic [ROUTE_W-1:0] code,
                                             input logic neg);
    logic [15:0] v;
    v = 16'h0000;
    if (code <= ROUTE_PIN_LAST) begin
      v[{neg, code[2:0]}] = 1'b1;
    end
    return v;
  endfunction : pin_onehot

  // Selector pair a drives the mux; pair b held for the core's second state
  wire [ROUTE_W-1:0] pos_code [2];
  wire [ROUTE_W-1:0] neg_code [2];
  assign pos_code[0] = sel_reg[0];
  assign neg_code[0] = sel_reg[2];
  assign pos_code[1] = sel_reg[4];
  assign neg_code[1] = sel_reg[6];

  // Registered route outputs
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int s = 0; s < 2; s++) begin
        pos_pin_reg[s] <= 16'h0000;
        neg_pin_reg[s] <= 16'h0000;
      end
      pos_dac_reg <= 2'b00;
      pos_gnd_reg <= 2'b00;
      neg_dac_reg <= 2'b00;
      neg_gnd_reg <= 2'b00;
      ref_onehot_reg <= 4'h0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        pos_pin_reg[s] <= pin_onehot(pos_code[s], 1'b0);
        neg_pin_reg[s] <= pin_onehot(neg_code[s], 1'b1);
        pos_dac_reg[s] <= pos_code[s] == ROUTE_POS_DAC;
        pos_gnd_reg[s] <= pos_code[s] == ROUTE_POS_GND;
        neg_dac_reg[s] <= neg_code[s] == ROUTE_NEG_DAC;
        neg_gnd_reg[s] <= neg_code[s] == ROUTE_NEG_GND;
      end
      ref_onehot_reg <= 4'h1 << ref_reg;
    end
  end

  assign POS_PIN_SEL0 = pos_pin_reg[0];
  assign POS_DAC_SEL0 = pos_dac_reg[0];
  assign POS_GND_SEL0 = pos_gnd_reg[0];
  assign NEG_PIN_SEL0 = neg_pin_reg[0];
  assign NEG_DAC_SEL0 = neg_dac_reg[0];
  assign NEG_GND_SEL0 = neg_gnd_reg[0];
  assign POS_PIN_SEL1 = pos_pin_reg[1];
  assign POS_DAC_SEL1 = pos_dac_reg[1];
  assign POS_GND_SEL1 = pos_gnd_reg[1];
  assign NEG_PIN_SEL1 = neg_pin_reg[1];
  assign NEG_DAC_SEL1 = neg_dac_reg[1];
  assign NEG_GND_SEL1 = neg_gnd_reg[1];
  assign REF_SEL_ONEHOT = ref_onehot_reg; // bit0 1V, bit1 supply, bit2 pin0, bit3 pin1
endmodule : adc_input_select_and_results

// file: common/adc_sel_pkg.sv
// Purpose: Shared constants for the converter input select and result block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Selector registers sit at locally chosen offsets
package adc_sel_pkg;
  localparam logic [7:0] OFF_SEQ0_POS_A = 8'h00;
  localparam logic [7:0] OFF_SEQ0_POS_B = 8'h04;
  localparam logic [7:0] OFF_SEQ0_NEG_A = 8'h08;
  localparam logic [7:0] OFF_SEQ0_NEG_B = 8'h0C;
  localparam logic [7:0] OFF_SEQ1_POS_A = 8'h10;
  localparam logic [7:0] OFF_SEQ1_POS_B = 8'h14;
  localparam logic [7:0] OFF_SEQ1_NEG_A = 8'h18;
  localparam logic [7:0] OFF_SEQ1_NEG_B = 8'h1C;
  localparam logic [7:0] OFF_REF_SEL = 8'h20;
  localparam logic [7:0] OFF_PRECISION = 8'h24;
  localparam logic [7:0] OFF_LAST_VALUE0 = 8'h60;
  localparam logic [7:0] OFF_LAST_VALUE1 = 8'h64;
  localparam logic [7:0] OFF_PARAMETERS = 8'h80;
  localparam logic [7:0] OFF_RESULT_BASE = 8'h84;
  localparam logic [7:0] RESULT_STRIDE = 8'h04;
  localparam int NUM_RESULTS = 8;
  localparam logic [31:0] PARAMETERS_RESET = 32'h00000808;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam int PARAM_CHAN_LSB = 8;
  localparam int PARAM_STATES_LSB = 0;
  localparam int ROUTE_W = 4;
  localparam int REF_W = 2;
  localparam int PREC_W = 2;
  localparam int RAW_W = 12;
  localparam logic [3:0] ROUTE_PIN_LAST = 4'h7;
  localparam logic [3:0] ROUTE_POS_DAC = 4'h8;
  localparam logic [3:0] ROUTE_POS_GND = 4'hA;
  localparam logic [3:0] ROUTE_NEG_DAC = 4'h8;
  localparam logic [3:0] ROUTE_NEG_GND = 4'h9;
  localparam logic [3:0] NEG_PIN_BASE = 4'h8;
  localparam logic [1:0] REF_INT_1V = 2'h0;
  localparam logic [1:0] REF_INT_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXT_PIN_0 = 2'h2;
  localparam logic [1:0] REF_EXT_PIN_1 = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Precision codes: 12, 10, 8 bits; fourth code kept 12
  localparam logic [1:0] PREC_12 = 2'h0;
  localparam logic [1:0] PREC_10 = 2'h1;
  localparam logic [1:0] PREC_8 = 2'h2;
endpackage : adc_sel_pkg

// file: common/result_bus_if.sv
// Purpose: Write and read port bundle of the result store
// Assumes: One write and one read per cycle
// Notes: Read data is registered in the store
`timescale 1ns/10ps
interface result_bus_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [31:0] wr_data;
  logic [2:0] rd_idx;
  logic [31:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : result_bus_if

// file: src/result_store.sv
// Purpose: Eight-word store of conversion results
// Assumes: Single clock, registered read
// Notes: Read data follows index one cycle later
`timescale 1ns/10ps
module result_store (
  input wire CLOCK,
  input wire RST_N,
  result_bus_if.store bus
);
  import adc_sel_pkg::*;

  logic [31:0] mem_reg [NUM_RESULTS];
  logic [31:0] rd_reg;

  // Reset to zero so results read defined values before a conversion
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_RESULTS; i++) begin
        mem_reg[i] <= RESULT_RESET;
      end
      rd_reg <= RESULT_RESET;
    end else begin
      if (bus.wr_en) begin
        mem_reg[bus.wr_idx] <= bus.wr_data;
      end
      rd_reg <= mem_reg[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_reg;
endmodule : result_store

// file: bench/sel_chk.sv
// Purpose: Port checks for the select and result block
// Assumes: One clock, reset async active low
// Notes: Remembers the last accepted write to judge its answer
`timescale 1ns/10ps
module sel_chk
  import adc_sel_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic [15:0] POS_PIN_SEL0,
  input wire logic POS_DAC_SEL0,
  input wire logic POS_GND_SEL0,
  input wire logic [15:0] NEG_PIN_SEL0,
  input wire logic NEG_DAC_SEL0,
  input wire logic NEG_GND_SEL0,
  input wire logic [15:0] POS_PIN_SEL1,
  input wire logic POS_DAC_SEL1,
  input wire logic POS_GND_SEL1,
  input wire logic [15:0] NEG_PIN_SEL1,
  input wire logic NEG_DAC_SEL1,
  input wire logic NEG_GND_SEL1,
  input wire logic [3:0] REF_SEL_ONEHOT
);
  logic [7:0] aw_reg;
  logic [31:0] wd_reg;
  // Last taken address and data; the answer comes later
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_reg <= 8'h00;
      wd_reg <= 32'h00000000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_reg <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd_reg <= S_AXI_WDATA;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_ref_onehot;
    $past(RST_N) |-> $onehot(REF_SEL_ONEHOT);
  endproperty
  a_ref_onehot: assert property (p_ref_onehot) else $error("ref select not one-hot");
  property p_pos0;
    $onehot0({POS_PIN_SEL0, POS_DAC_SEL0, POS_GND_SEL0}) && POS_PIN_SEL0[15:8] == 8'h00;
  endproperty
  a_pos0: assert property (p_pos0) else $error("seq0 positive route bad");
  property p_neg0;
    $onehot0({NEG_PIN_SEL0, NEG_DAC_SEL0, NEG_GND_SEL0}) && NEG_PIN_SEL0[7:0] == 8'h00;
  endproperty
  a_neg0: assert property (p_neg0) else $error("seq0 negative route bad");
  property p_seq1;
    $onehot0({POS_PIN_SEL1, POS_DAC_SEL1, POS_GND_SEL1}) && POS_PIN_SEL1[15:8] == 8'h00
      && $onehot0({NEG_PIN_SEL1, NEG_DAC_SEL1, NEG_GND_SEL1}) && NEG_PIN_SEL1[7:0] == 8'h00;
  endproperty
  a_seq1: assert property (p_seq1) else $error("seq1 route bad");
  property p_param;
    S_AXI_ARREADY && S_AXI_ARADDR == OFF_PARAMETERS
      |-> ##[1:2] (S_AXI_RVALID && S_AXI_RDATA == PARAMETERS_RESET);
  endproperty
  a_param: assert property (p_param) else $error("parameter word wrong");
  property p_ro_refused;
    $rose(S_AXI_BVALID) && aw_reg >= OFF_LAST_VALUE0 |-> S_AXI_BRESP == AXI_SLVERR;
  endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only write accepted");
  property p_dac_route;
    $rose(S_AXI_BVALID) && S_AXI_BRESP == AXI_OKAY && aw_reg == OFF_SEQ0_POS_A
      && wd_reg[3:0] == ROUTE_POS_DAC |-> ##[0:2] POS_DAC_SEL0;
  endproperty
  a_dac_route: assert property (p_dac_route) else $error("dac route missing");
  property p_ref_route;
    $rose(S_AXI_BVALID) && S_AXI_BRESP == AXI_OKAY && aw_reg == OFF_REF_SEL
      |-> ##[0:2] REF_SEL_ONEHOT == (4'h1 << wd_reg[1:0]);
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("ref route wrong");
  c_param: cover property (S_AXI_ARREADY && S_AXI_ARADDR == OFF_PARAMETERS);
  c_dac: cover property (POS_DAC_SEL0);
  c_gnd: cover property (NEG_GND_SEL1);
endmodule : sel_chk

// file: bench/input_route_code_core_model.sv
// Purpose: Behavioural converter core handing back raw codes
// Assumes: One conversion at a time, started by the bench
// Notes: Raw bus toggles between results so stale codes never look valid
`timescale 1ns/10ps
module input_route_code_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] slot,
  input wire logic seq,
  input wire logic [11:0] raw,
  input wire logic [3:0] lag,
  output logic input_route_code_done,
  output logic [2:0] input_route_code_slot,
  output logic input_route_code_seq,
  output logic [11:0] input_route_code_raw
);
  logic [4:0] wait_reg;
  logic [11:0] raw_reg;
  // Lag gives a prompt or a slow conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 5'h00;
      raw_reg <= 12'h000;
      input_route_code_done <= 1'h0;
      input_route_code_slot <= 3'h0;
      input_route_code_seq <= 1'h0;
      input_route_code_raw <= 12'h000;
    end else begin
      input_route_code_done <= 1'h0;
      input_route_code_raw <= ~input_route_code_raw;
      if (start) begin
        wait_reg <= {1'h0, lag} + 5'h01;
        raw_reg <= raw;
        input_route_code_slot <= slot;
        input_route_code_seq <= seq;
      end else if (wait_reg != 5'h00) begin
        wait_reg <= wait_reg - 5'h01;
        if (wait_reg == 5'h01) begin
          input_route_code_done <= 1'h1;
          input_route_code_raw <= raw_reg;
        end
      end
    end
  end
endmodule : input_route_code_core_model

// file: bench/testbench.sv
// Purpose: Self-checking bench for the select and result block
// Assumes: Bench is the bus master, model is the converter core
// Notes: Sign extension taken from the low bits of the raw code
`timescale 1ns/10ps
module testbench;
  import adc_sel_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, start = 1'h0, seq = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [2:0] slot = 3'h0;
  logic [11:0] raw = 12'h000;
  logic [3:0] lag = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, done, cseq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] cslot;
  logic [11:0] craw;
  logic [15:0] pp0, np0, pp1, np1;
  logic pd0, pg0, nd0, ng0, pd1, pg1, nd1, ng1;
  logic [3:0] ref_oh;
  int n_errors = 0, n_tests = 0, cyc = 0;
  adc_input_select_and_results dut_u (.CLOCK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .INPUT_ROUTE_CODE_DONE(done), .INPUT_ROUTE_CODE_SLOT(cslot), .INPUT_ROUTE_CODE_SEQ(cseq), .INPUT_ROUTE_CODE_RAW(craw),
    .POS_PIN_SEL0(pp0), .POS_DAC_SEL0(pd0), .POS_GND_SEL0(pg0), .NEG_PIN_SEL0(np0),
    .NEG_DAC_SEL0(nd0), .NEG_GND_SEL0(ng0), .POS_PIN_SEL1(pp1), .POS_DAC_SEL1(pd1),
    .POS_GND_SEL1(pg1), .NEG_PIN_SEL1(np1), .NEG_DAC_SEL1(nd1), .NEG_GND_SEL1(ng1),
    .REF_SEL_ONEHOT(ref_oh));
  input_route_code_core_model core_u (.clk(clk), .rst_n(rst_n), .start(start), .slot(slot), .seq(seq),
    .raw(raw), .lag(lag), .input_route_code_done(done), .input_route_code_slot(cslot), .input_route_code_seq(cseq),
    .input_route_code_raw(craw));
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 'x;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int t = 0; t < 60; t++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        bready <= 1'h0;
        r = bresp;
        break;
      end
    end
    chk("bresp", 32'(er), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    d = 'x;
    r = 'x;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int t = 0; t < 60; t++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rready <= 1'h0;
        d = rdata;
        r = rresp;
        break;
      end
    end
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask : rd
  // Fixed words, read-only refusals, unmapped place, reference codes
  task automatic t_regs;
    // One more edge so the first registered reference word has landed
    @(posedge clk);
    chk("ref after reset", 32'h1, 32'(ref_oh));
    rd(OFF_PARAMETERS, PARAMETERS_RESET, AXI_OKAY);
    wr(OFF_PARAMETERS, 32'h00000000, AXI_SLVERR);
    rd(OFF_PARAMETERS, PARAMETERS_RESET, AXI_OKAY);
    for (int n = 0; n < NUM_RESULTS; n++) rd(OFF_RESULT_BASE + 8'(4 * n), 32'h0, AXI_OKAY);
    wr(OFF_RESULT_BASE + 8'h1C, 32'hFFFFFFFF, AXI_SLVERR);
    rd(8'h40, 32'h00000000, AXI_SLVERR);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_REF_SEL, 32'(c), AXI_OKAY);
      // Route word is launched at the answer edge; look one edge later
      @(posedge clk);
      chk("ref select", 32'(4'h1 << c), 32'(ref_oh));
    end
  endtask : t_regs
  function automatic logic [17:0] route_of(input int i);
    case (i)
      0: return {pp0, pd0, pg0};
      2: return {np0, nd0, ng0};
      4: return {pp1, pd1, pg1};
      default: return {np1, nd1, ng1};
    endcase
  endfunction : route_of
  // Pin, DAC and ground one-hot per selector; unlisted codes select nothing
  function automatic logic [17:0] route_exp(input int i, input logic [3:0] c);
    logic neg;
    neg = (i % 4) == 2;
    if (c <= 4'h7) return {16'h0001 << (c + (neg ? 4'h8 : 4'h0)), 2'h0};
    if (c == 4'h8) return 18'h00002;
    if (c == (neg ? 4'h9 : 4'hA)) return 18'h00001;
    return 18'h00000;
  endfunction : route_exp
  task automatic t_routes;
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 11; c++) begin
        // Software keeps to listed codes: 9 is unlisted on plus side, 10 on minus side
        if (c == (((i % 4) < 2) ? 9 : 10)) continue;
        wr(8'(4 * i), 32'(c), AXI_OKAY);
        rd(8'(4 * i), 32'(c), AXI_OKAY);
        if (i % 2 == 0) chk("route", 32'(route_exp(i, 4'(c))), 32'(route_of(i)));
      end
    end
  endtask : t_routes
  // Raw A5A: 12 bit FFFFFA5A, 10 bit FFFFFE5A, 8 bit 0000005A
  task automatic t_results;
    logic [31:0] e;
    for (int p = 0; p < 4; p++) begin
      wr(OFF_PRECISION, 32'(p), AXI_OKAY);
      start <= 1'h1;
      slot <= 3'(7 - p);
      seq <= p[0];
      raw <= 12'hA5A;
      lag <= 4'(3 * p);
      @(posedge clk);
      start <= 1'h0;
      for (int t = 0; t < 40 && !done; t++) @(posedge clk);
      e = (p == 1) ? 32'hFFFFFE5A : (p == 2) ? 32'h0000005A : 32'hFFFFFA5A;
      rd(OFF_RESULT_BASE + 8'(4 * (7 - p)), e, AXI_OKAY);
      rd(p[0] ? OFF_LAST_VALUE1 : OFF_LAST_VALUE0, e, AXI_OKAY);
    end
  endtask : t_results
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs;
    t_routes;
    t_results;
    end_sim;
  end
endmodule : testbench
bind adc_input_select_and_results sel_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .POS_PIN_SEL0(POS_PIN_SEL0), .POS_DAC_SEL0(POS_DAC_SEL0), .POS_GND_SEL0(POS_GND_SEL0),
  .NEG_PIN_SEL0(NEG_PIN_SEL0), .NEG_DAC_SEL0(NEG_DAC_SEL0), .NEG_GND_SEL0(NEG_GND_SEL0),
  .POS_PIN_SEL1(POS_PIN_SEL1), .POS_DAC_SEL1(POS_DAC_SEL1), .POS_GND_SEL1(POS_GND_SEL1),
  .NEG_PIN_SEL1(NEG_PIN_SEL1), .NEG_DAC_SEL1(NEG_DAC_SEL1), .NEG_GND_SEL1(NEG_GND_SEL1),
  .REF_SEL_ONEHOT(REF_SEL_ONEHOT));
